// [logic/bpss_top.sv]
// Function
// RULE_01: Full bridge drives at most two outputs.
// RULE_02: Forward: output_a on, output_d modulated.
// RULE_03: Reverse: output_c on, output_b modulated.
// RULE_04: New direction takes effect next PWM cycle.
// RULE_05: Unmodulated outputs switch one prescaled tick early.
// RULE_06: Modulated outputs inactive during direction switch.
// RULE_07: No dead band in full bridge.
// RULE_08: Firmware lowers duty before reversing near full.
// RULE_09: Dead band delays only inactive-to-active edges.
// RULE_10: Dead band is seven-bit instruction-cycle count.
// RULE_11: Enabled shutdown event forces outputs immediately.
// RULE_12: Sources: comparator one, two, fault pin.
// RULE_13: Three-bit source select; zero disables.
// RULE_14: Pairs a/c, b/d drive low, high, float.
// RULE_15: Status set by event holds shutdown.
// RULE_16: Status cleared by firmware or auto restart.
// RULE_17: Shutdown spans period; resume at period start.
// RULE_18: Status writes ignored while cause active.
// RULE_19: Restart enable lives in dead-band register bit 7.
// RULE_20: Firmware sets pins as outputs beforehand.
// RULE_21: Source select decode over three sources.
// RULE_22: Pair state: 00 low, 01 high, 1x float.
// RULE_23: Writing status one forces shutdown.
// RULE_24: Dead band above duty keeps output inactive.
// RULE_25: Switch point is last tick before period reset.
// RULE_26: Down-counter loaded at each rising edge.
`timescale 1ns/10ps
module bpss_top
  import bpss_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned TMR_W = 8,
  parameter int unsigned DB_W = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic pwm_in,
  input wire logic period_start,
  input wire logic [TMR_W-1:0] tmr_count,
  input wire logic [TMR_W-1:0] period_value,
  input wire logic comp1_in,
  input wire logic comp2_in,
  input wire logic fault_input_n,
  output logic output_a,
  output logic output_b,
  output logic output_c,
  output logic output_d,
  output logic output_a_oe,
  output logic output_b_oe,
  output logic output_c_oe,
  output logic output_d_oe
);

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [TCY_W-1:0] tcy_cnt;
    logic [1:0] mode;
    logic [1:0] act_mode;
    logic status;
    logic [2:0] src;
    logic [1:0] pss_ac;
    logic [1:0] pss_bd;
    logic restart;
    logic [DB_W-1:0] db;
    logic hold;
    logic sd;
    logic pwm_prev;
    logic [DB_W-1:0] cnt_a;
    logic [DB_W-1:0] cnt_b;
    logic [3:0] out;
    logic [3:0] oe;
    logic awv;
    logic [ADDR_W-1:0] aw_addr;
    logic wv;
    logic [7:0] wdata;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    bpss_rd_t rd;
    logic arready;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } bpss_state_t;

  bpss_state_t q;
  bpss_state_t d;

  logic cause_c;
  logic sd_c;
  logic sw_c;
  logic tcy_en;
  logic wr_fire;
  logic full_c;

  function automatic logic [DB_W-1:0] db_step(
    input logic rise,
    input logic [DB_W-1:0] cur,
    input logic [DB_W-1:0] load,
    input logic tick
  );
    if (rise) begin
      db_step = load;
    end else if (tick && cur != '0) begin
      db_step = cur - 1'b1;
    end else begin
      db_step = cur;
    end
  endfunction

  // Returns {enable, level} for one output pair in shutdown.
  function automatic logic [1:0] pss_drive(input logic [1:0] pss);
    if (pss[1]) begin
      pss_drive = 2'h0;
    end else begin
      pss_drive = {1'b1, pss[0]};
    end
  endfunction

  assign tcy_en = (q.tcy_cnt == TCY_W'(TCY_CYCLES - 1));
  assign cause_c =
    |(q.src & {~q.sync2[2], q.sync2[1:0]}); // RULE_12 RULE_13 RULE_21
  assign sd_c = cause_c | q.status | q.hold; // RULE_11 RULE_15
  assign full_c = q.act_mode[0] && q.mode[0];
  // The switch interval is the whole last timer step before reset.
  assign sw_c = full_c && (q.mode[1] != q.act_mode[1]) &&
    (tmr_count == period_value); // RULE_05 RULE_25
  assign wr_fire = q.awv && q.wv && !q.bvalid;

  always_comb begin
    logic [1:0] drv_ac;
    logic [1:0] drv_bd;
    logic dir_u;
    logic mod_en;
    d = q;
    drv_ac = pss_drive(q.pss_ac);
    drv_bd = pss_drive(q.pss_bd);
    dir_u = 1'b0;
    mod_en = 1'b0;
    d.sync1 = {fault_input_n, comp2_in, comp1_in};
    d.sync2 = q.sync1;
    d.tcy_cnt = tcy_en ? '0 : q.tcy_cnt + 1'b1;

    if (s_axi_awvalid && q.awready) begin
      d.awv = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.wv = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      d.wlane = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Auto restart clears first, so a live cause still wins below.
    if (q.restart && !cause_c) begin
      d.status = 1'b0; // RULE_16 RULE_19
    end

    if (wr_fire) begin
      d.awv = 1'b0;
      d.wv = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.aw_addr)
        OFS_PWM_CONTROL: begin
          if (q.wlane) begin
            d.mode = q.wdata[MODE_HI:MODE_LO]; // RULE_04
          end
        end
        OFS_SHUTDOWN_CONTROL: begin
          if (q.wlane) begin
            d.src = q.wdata[SD_SRC_HI:SD_SRC_LO];
            d.pss_ac = q.wdata[SD_AC_HI:SD_AC_LO];
            d.pss_bd = q.wdata[SD_BD_HI:SD_BD_LO];
            if (q.wdata[SD_STATUS_BIT]) begin
              d.status = 1'b1; // RULE_23
            end else if (!cause_c) begin
              d.status = 1'b0; // RULE_16 RULE_18
            end
          end
        end
        OFS_DEAD_BAND: begin
          if (q.wlane) begin
            d.restart = q.wdata[DB_RESTART_BIT]; // RULE_19
            d.db = q.wdata[DB_COUNT_HI:DB_COUNT_LO]; // RULE_10
          end
        end
        OFS_BRIDGE_STATUS: begin
          d.bresp = RESP_OKAY;
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    d.awready = !d.awv && !d.bvalid;
    d.wready = !d.wv && !d.bvalid;

    if (cause_c) begin
      d.status = 1'b1; // RULE_15
    end

    case (q.rd)
      BPSS_RD_IDLE: begin
        if (s_axi_arvalid && q.arready) begin
          d.rd = BPSS_RD_DATA;
          d.rresp = RESP_OKAY;
          case (s_axi_araddr)
            OFS_PWM_CONTROL: begin
              d.rdata = {q.mode, 6'h00};
            end
            OFS_SHUTDOWN_CONTROL: begin
              d.rdata = {q.status, q.src, q.pss_ac, q.pss_bd};
            end
            OFS_DEAD_BAND: begin
              d.rdata = {q.restart, q.db};
            end
            OFS_BRIDGE_STATUS: begin
              d.rdata = {q.out, q.sd, q.hold, cause_c, q.act_mode[1]};
            end
            default: begin
              d.rdata = 8'h00;
              d.rresp = RESP_SLVERR;
            end
          endcase
        end
      end
      BPSS_RD_DATA: begin
        if (s_axi_rready) begin
          d.rd = BPSS_RD_IDLE;
        end
      end
      default: begin
        d.rd = BPSS_RD_IDLE;
      end
    endcase
    d.arready = (d.rd == BPSS_RD_IDLE);

    // Mode and direction are double-buffered at the period boundary.
    if (period_start) begin
      d.act_mode = q.mode; // RULE_04 RULE_25
      d.hold = q.status | d.status; // RULE_17
    end else if (d.status) begin
      d.hold = 1'b1; // RULE_17
    end

    d.pwm_prev = pwm_in;
    d.cnt_a = db_step(pwm_in && !q.pwm_prev, q.cnt_a, q.db,
      tcy_en); // RULE_26
    d.cnt_b = db_step(!pwm_in && q.pwm_prev, q.cnt_b, q.db,
      tcy_en); // RULE_26

    d.out = 4'h0;
    d.oe = 4'hf;
    // Drive from the mode just latched, or the old direction flashes back.
    case (d.act_mode)
      MODE_HALF: begin
        // A delay longer than the duty leaves the edge never reached.
        d.out[0] = pwm_in && d.cnt_a == '0; // RULE_09 RULE_24
        d.out[1] = !pwm_in && d.cnt_b == '0; // RULE_09 RULE_24
      end
      MODE_FWD, MODE_REV: begin
        dir_u = sw_c ? q.mode[1] : d.act_mode[1]; // RULE_05
        mod_en = pwm_in && !sw_c; // RULE_06 RULE_07
        d.out[0] = !dir_u; // RULE_02
        d.out[2] = dir_u; // RULE_03
        d.out[3] = !d.act_mode[1] && mod_en; // RULE_01 RULE_02
        d.out[1] = d.act_mode[1] && mod_en; // RULE_01 RULE_03
      end
      default: begin
        d.out[0] = pwm_in;
      end
    endcase

    d.sd = sd_c;
    if (sd_c) begin
      d.oe = {drv_bd[1], drv_ac[1], drv_bd[1], drv_ac[1]}; // RULE_14
      d.out = {drv_bd[0], drv_ac[0], drv_bd[0], drv_ac[0]}; // RULE_22
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.sync1[2] <= 1'b1;
      q.sync2[2] <= 1'b1;
      q.mode <= RST_PWM_MODE;
      q.act_mode <= RST_PWM_MODE;
      q.status <= RST_SHUTDOWN_CONTROL[SD_STATUS_BIT];
      q.src <= RST_SHUTDOWN_CONTROL[SD_SRC_HI:SD_SRC_LO];
      q.pss_ac <= RST_SHUTDOWN_CONTROL[SD_AC_HI:SD_AC_LO];
      q.pss_bd <= RST_SHUTDOWN_CONTROL[SD_BD_HI:SD_BD_LO];
      q.restart <= RST_DEAD_BAND[DB_RESTART_BIT];
      q.db <= RST_DEAD_BAND[DB_COUNT_HI:DB_COUNT_LO];
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = (q.rd == BPSS_RD_DATA);
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign s_axi_rresp = q.rresp;
  assign output_a = q.out[0];
  assign output_b = q.out[1];
  assign output_c = q.out[2];
  assign output_d = q.out[3];
  assign output_a_oe = q.oe[0];
  assign output_b_oe = q.oe[1];
  assign output_c_oe = q.oe[2];
  assign output_d_oe = q.oe[3];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  two_active_a: assert property ( // RULE_01
    ($past(d.act_mode[0]) && !q.sd) |-> ($countones(q.out) <= 2))
    else $error("Full bridge drives more than two outputs.");

  fwd_drive_a: assert property ( // RULE_02
    (d.act_mode == MODE_FWD && !sw_c && !sd_c) |=>
      (output_a && !output_b && !output_c && output_d == $past(pwm_in)))
    else $error("Forward drive pattern wrong.");

  rev_drive_a: assert property ( // RULE_03
    (d.act_mode == MODE_REV && !sw_c && !sd_c) |=>
      (output_c && !output_a && !output_d && output_b == $past(pwm_in)))
    else $error("Reverse drive pattern wrong.");

  dir_latch_a: assert property ( // RULE_04
    (period_start ##1 !period_start) |-> q.act_mode == $past(q.mode))
    else $error("Direction not taken at period start.");

  switch_quiet_a: assert property ( // RULE_06
    (sw_c && !sd_c) |=>
      (!output_b && !output_d && output_c == $past(q.mode[1])))
    else $error("Direction switch interval wrong.");

  status_set_a: assert property ( // RULE_15
    cause_c |=> (q.status && q.sd))
    else $error("Shutdown event did not set status.");

  write_ignored_a: assert property ( // RULE_18
    (cause_c && q.status && wr_fire) |=> q.status)
    else $error("Status cleared while cause active.");

  period_hold_a: assert property ( // RULE_17
    (period_start && q.status) |=> (q.hold && sd_c))
    else $error("Shutdown not held for the period.");

  pair_high_a: assert property ( // RULE_22
    (sd_c && q.pss_ac == PSS_HIGH && q.pss_bd == PSS_LOW) |=>
      (output_a && output_c && output_a_oe && !output_b && output_b_oe))
    else $error("Pair shutdown drive wrong.");

  dead_band_a: assert property ( // RULE_09
    (d.act_mode == MODE_HALF && !sd_c && pwm_in && !q.pwm_prev &&
      q.db != '0) |=> !output_a)
    else $error("Dead band not applied on rising edge.");

  cover_reverse_c: cover property (sw_c ##1 period_start);
  cover_restart_c: cover property ($fell(q.status) && q.restart);
  cover_float_c: cover property (q.sd && !output_a_oe);

endmodule

// [common/bpss_pkg.sv]
package bpss_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_PWM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_SHUTDOWN_CONTROL = 8'h04;
  localparam logic [7:0] OFS_DEAD_BAND = 8'h08;
  localparam logic [7:0] OFS_BRIDGE_STATUS = 8'h0c;

  // Values after reset.
  localparam logic [1:0] RST_PWM_MODE = 2'h0;
  localparam logic [7:0] RST_SHUTDOWN_CONTROL = 8'h00;
  localparam logic [7:0] RST_DEAD_BAND = 8'h00;

  // Field positions.
  localparam int unsigned MODE_LO = 6;
  localparam int unsigned MODE_HI = 7;
  localparam int unsigned SD_STATUS_BIT = 7;
  localparam int unsigned SD_SRC_LO = 4;
  localparam int unsigned SD_SRC_HI = 6;
  localparam int unsigned SD_AC_LO = 2;
  localparam int unsigned SD_AC_HI = 3;
  localparam int unsigned SD_BD_LO = 0;
  localparam int unsigned SD_BD_HI = 1;
  localparam int unsigned DB_RESTART_BIT = 7;
  localparam int unsigned DB_COUNT_LO = 0;
  localparam int unsigned DB_COUNT_HI = 6;

  // Output configurations; bit 1 is the full-bridge direction.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_FWD = 2'h1;
  localparam logic [1:0] MODE_HALF = 2'h2;
  localparam logic [1:0] MODE_REV = 2'h3;

  // Shutdown source bits and pair states.
  localparam int unsigned SRC_COMP1 = 0;
  localparam int unsigned SRC_COMP2 = 1;
  localparam int unsigned SRC_FAULT = 2;
  localparam logic [1:0] PSS_LOW = 2'h0;
  localparam logic [1:0] PSS_HIGH = 2'h1;

  // Instruction cycle timing: aclk stands for the oscillator.
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned TOSC_PS = 4000;
  localparam int unsigned TOSC_PER_TCY = 4;
  localparam int unsigned TCY_CYCLES =
    (TOSC_PER_TCY * TOSC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TCY_W = $clog2(TCY_CYCLES);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {BPSS_RD_IDLE, BPSS_RD_DATA} bpss_rd_t;

endpackage

// [bench/bpss_bridge_model.sv]
`timescale 1ns/10ps
module bpss_bridge_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] drv,
  input wire logic [3:0] oe,
  output logic [3:0] pin,
  output logic [7:0] n_shoot
);
  // A released gate is held low by the board's pull-downs.
  // This keeps the switch off rather than leaving it to chance.
  assign pin = drv & oe;
  // Output_a with output_b, and output_c with output_d, share one leg.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_shoot <= 8'h00;
    end else if ((pin[0] && pin[1]) || (pin[2] && pin[3])) begin
      n_shoot <= n_shoot + 8'h01;
    end
  end
endmodule

// [bench/bpss_top_test.sv]
`timescale 1ns/10ps
module bpss_top_test;
  import bpss_pkg::*;
  localparam logic [7:0] PER = 8'h27;
  localparam logic [7:0] DUTY = 8'h14;
  logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara, n_shoot, pe;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp, ac, bd;
  logic c1, c2, flt_n, hit;
  logic pwm = 1'b0;
  logic pst = 1'b0;
  logic [7:0] tmr = 8'h00;
  logic [3:0] drv, oe, pin;
  int n_mismatch, tests_run;

  bpss_top bpss_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .pwm_in(pwm), .period_start(pst),
    .tmr_count(tmr), .period_value(PER), .comp1_in(c1), .comp2_in(c2),
    .fault_input_n(flt_n), .output_a(drv[0]), .output_b(drv[1]),
    .output_c(drv[2]), .output_d(drv[3]), .output_a_oe(oe[0]),
    .output_b_oe(oe[1]), .output_c_oe(oe[2]), .output_d_oe(oe[3])
  );

  bpss_bridge_model bpss_bridge_model_i (
    .aclk(aclk), .aresetn(aresetn), .drv(drv), .oe(oe), .pin(pin),
    .n_shoot(n_shoot)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Timer stand-in with a prescale of one, so the switch window is one tick.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tmr <= 8'h00;
    end else begin
      tmr <= (tmr == PER) ? 8'h00 : tmr + 8'h01;
      pst <= (tmr == PER);
      pwm <= (tmr == PER) || (tmr + 8'h01 < DUTY);
    end
  end

  task automatic chk_reg(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: reg %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [7:0] exp, input logic [7:0] m);
    tests_run++;
    if (({oe, drv} & m) !== (exp & m)) begin
      n_mismatch++;
      $display("mismatch at %0t: pins %h want %h", $time, {oe, drv}, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    logic pa, pw;
    @(posedge aclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'h0, d};
    br <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awr === 1'b1) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr === 1'b1) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    br <= 1'b0;
    chk_reg({32'h0, bresp}, {32'h0, er});
  endtask

  task automatic axr_chk(input logic [7:0] a, input logic [7:0] ed,
                         input logic [1:0] er);
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    rr <= 1'b0;
    chk_reg({rresp, rd}, {er, 24'h0, ed});
  endtask

  task automatic at_tmr(input logic [7:0] v);
    do begin
      @(posedge aclk);
      #1;
    end while (tmr !== v);
  endtask

  task automatic cause(input int k, input logic on);
    @(posedge aclk);
    c1 <= on && k == 0;
    c2 <= on && k == 1;
    flt_n <= !(on && k == 2);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {awv, wv, br, arv, rr, c1, c2, aresetn} = 8'h00;
    {awa, ara, wd} = '0;
    flt_n = 1'b1;
    n_mismatch = 0;
    tests_run = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr_chk(OFS_PWM_CONTROL, 8'h00, RESP_OKAY);
    axr_chk(OFS_SHUTDOWN_CONTROL, 8'h00, RESP_OKAY);
    axr_chk(OFS_DEAD_BAND, 8'h00, RESP_OKAY);
    axr_chk(8'h10, 8'h00, RESP_SLVERR);
    axw(8'h10, 8'hff, RESP_SLVERR);
    axw(OFS_DEAD_BAND, 8'h02, RESP_OKAY);
    axw(OFS_PWM_CONTROL, 8'h40, RESP_OKAY);
    at_tmr(8'h00);
    at_tmr(8'h02);
    chk_pins(8'hf9, 8'hff);
    at_tmr(8'h1e);
    chk_pins(8'hf1, 8'hff);
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        hit = s[k];
        axw(OFS_SHUTDOWN_CONTROL, {1'b0, s[2:0], 4'h0}, RESP_OKAY);
        cause(k, 1'b1);
        repeat (4) @(posedge aclk);
        #1;
        chk_pins({3'h0, 1'b1, 3'h0, !hit}, 8'h11);
        axw(OFS_SHUTDOWN_CONTROL, {1'b0, s[2:0], 4'h0}, RESP_OKAY);
        axr_chk(OFS_SHUTDOWN_CONTROL, {hit, s[2:0], 4'h0}, RESP_OKAY);
        cause(k, 1'b0);
        repeat (4) @(posedge aclk);
        axw(OFS_SHUTDOWN_CONTROL, {1'b0, s[2:0], 4'h0}, RESP_OKAY);
        at_tmr(8'h02);
      end
    end
    for (int st = 0; st < 4; st++) begin
      ac = st[1:0];
      bd = ac ^ 2'h1;
      pe = {!bd[1], !ac[1], !bd[1], !ac[1], bd == 2'h1, ac == 2'h1,
            bd == 2'h1, ac == 2'h1};
      axw(OFS_SHUTDOWN_CONTROL, {4'h8, ac, bd}, RESP_OKAY);
      repeat (3) @(posedge aclk);
      #1;
      chk_pins(pe, 8'hff);
      at_tmr(8'h02);
      axw(OFS_SHUTDOWN_CONTROL, {4'h0, ac, bd}, RESP_OKAY);
      #1;
      chk_pins(pe, 8'hff);
      at_tmr(8'h02);
      chk_pins(8'hf9, 8'hff);
    end
    axw(OFS_PWM_CONTROL, 8'hc0, RESP_OKAY);
    at_tmr(PER);
    chk_pins(8'hf1, 8'hff);
    at_tmr(8'h00);
    chk_pins(8'hf4, 8'hff);
    at_tmr(8'h01);
    chk_pins(8'hf6, 8'hff);
    axw(OFS_DEAD_BAND, 8'h82, RESP_OKAY);
    axr_chk(OFS_DEAD_BAND, 8'h82, RESP_OKAY);
    axw(OFS_SHUTDOWN_CONTROL, 8'h10, RESP_OKAY);
    cause(0, 1'b1);
    repeat (4) @(posedge aclk);
    axr_chk(OFS_SHUTDOWN_CONTROL, 8'h90, RESP_OKAY);
    cause(0, 1'b0);
    repeat (4) @(posedge aclk);
    axr_chk(OFS_SHUTDOWN_CONTROL, 8'h10, RESP_OKAY);
    axw(OFS_PWM_CONTROL, 8'h80, RESP_OKAY);
    at_tmr(8'h00);
    at_tmr(8'h00);
    at_tmr(8'h03);
    chk_pins(8'h00, 8'h03);
    at_tmr(8'h10);
    chk_pins(8'h01, 8'h03);
    at_tmr(8'h16);
    chk_pins(8'h00, 8'h03);
    at_tmr(8'h24);
    chk_pins(8'h02, 8'h03);
    axw(OFS_DEAD_BAND, 8'h7f, RESP_OKAY);
    at_tmr(8'h00);
    at_tmr(8'h13);
    chk_pins(8'h00, 8'h03);
    chk_reg({26'h0, n_shoot}, 34'h0);
    tally_and_finish();
  end
endmodule
